// ---- include/casl_pkg.sv ----
// Constants, register map and command codes of the ALU subset and sleep block.
// Assumes a single 125 MHz core clock and an AXI4-Lite master with 8-bit addresses.
package casl_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned FADR_W     = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Register indices (byte address = 4 * index)
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_CMD   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_ACC   = 6'h01;
  localparam logic [IDX_W-1:0] IDX_STAT  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_WDOG  = 6'h03;
  localparam logic [IDX_W-1:0] IDX_FADR  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_FDATA = 6'h05;
  localparam logic [IDX_W-1:0] IDX_WAKE  = 6'h06;

  // ************************************************************
  // Command word fields
  // ************************************************************
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_DEST_BIT = 4;
  localparam int unsigned CMD_FADR_LSB = 8;
  localparam int unsigned CMD_LIT_LSB  = 16;

  // ************************************************************
  // Status register fields and reset values
  // ************************************************************
  localparam int unsigned ST_CARRY  = 0;
  localparam int unsigned ST_DC     = 1;
  localparam int unsigned ST_ZERO   = 2;
  localparam int unsigned ST_PD     = 3;
  localparam int unsigned ST_TO     = 4;
  localparam int unsigned ST_SLEEP  = 5;
  localparam logic        RST_TO    = 1'b1;
  localparam logic        RST_PD    = 1'b1;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  BYTE_MAX  = 8'hFF;

  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_SLEEP      = 4'h1,
    OP_LIT_MINUS  = 4'h2,
    OP_ROT_RIGHT  = 4'h3,
    OP_FILE_MINUS = 4'h4,
    OP_NIBBLE_EX  = 4'h5,
    OP_XOR_LIT    = 4'h6,
    OP_XOR_FILE   = 4'h7
  } casl_op_e;

  typedef enum logic {
    PWR_RUN   = 1'b0,
    PWR_SLEEP = 1'b1
  } casl_pwr_e;

endpackage

// ---- hw/casl_core.sv ----
// ALU subset, watchdog clearing and sleep control of an 8-bit core, behind AXI4-Lite.
// Assumes the master keeps AXI4-Lite signalling; all inputs synchronous to i_core_clk.
`timescale 1ns/1ps
module casl_core
  import casl_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_awvalid,
  output wire logic              o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output wire logic              o_wready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output wire logic              o_bvalid,
  input  wire logic              i_bready,
  output wire logic [1:0]        o_bresp,
  input  wire logic              i_arvalid,
  output wire logic              o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output wire logic              o_rvalid,
  input  wire logic              i_rready,
  output wire logic [DATA_W-1:0] o_rdata,
  output wire logic [1:0]        o_rresp,
  output wire logic              o_sleep,
  output wire logic              o_osc_en
);

  // ************************************************************
  // Bus slave state
  // ************************************************************
  logic              aw_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              w_held_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0]        rresp_ff;

  // ************************************************************
  // Core state
  // ************************************************************
  logic [7:0]        acc_ff;
  logic [7:0]        file_ff [FILE_DEPTH];
  logic [FADR_W-1:0] faddr_ff;
  logic              carry_ff;
  logic              dc_ff;
  logic              zero_ff;
  logic              timeout_flag_ff;
  logic              powerdown_flag_ff;
  logic [7:0]        watchdog_counter_ff;
  logic [7:0]        wdog_presc_ff;
  casl_pwr_e         pwr_ff;

  // ************************************************************
  // Handshakes and decode
  // ************************************************************
  wire              aw_fire  = i_awvalid && o_awready;
  wire              w_fire   = i_wvalid && o_wready;
  wire              ar_fire  = i_arvalid && o_arready;
  wire              wr_go    = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [IDX_W-1:0]  wr_idx   = awaddr_ff[ADDR_W-1:2];
  wire [IDX_W-1:0]  rd_idx   = i_araddr[ADDR_W-1:2];
  wire              wr_map   = (wr_idx <= IDX_WAKE);
  wire              rd_map   = (rd_idx <= IDX_WAKE);
  wire              lane0    = wstrb_ff[0];
  wire              running  = (pwr_ff == PWR_RUN);
  wire              wr_acc_sw  = wr_go && (wr_idx == IDX_ACC) && lane0;
  wire              wr_stat_sw = wr_go && (wr_idx == IDX_STAT) && lane0;
  wire              wr_fadr_sw = wr_go && (wr_idx == IDX_FADR) && lane0;
  wire              wr_fdat_sw = wr_go && (wr_idx == IDX_FDATA) && lane0;
  wire              wr_wake_sw = wr_go && (wr_idx == IDX_WAKE);
  // Commands are dropped while asleep: the oscillator is stopped, nothing executes
  wire              cmd_exec = wr_go && (wr_idx == IDX_CMD) && lane0 && running;

  wire [3:0]        cmd_op   = wdata_ff[CMD_OP_LSB +: 4];
  wire              cmd_dest = wdata_ff[CMD_DEST_BIT];
  wire [FADR_W-1:0] cmd_fadr = wdata_ff[CMD_FADR_LSB +: FADR_W];
  wire [7:0]        cmd_lit  = wdata_ff[CMD_LIT_LSB +: 8];
  wire [7:0]        fval     = file_ff[cmd_fadr];

  assign o_awready = !aw_held_ff && !bvalid_ff;
  assign o_wready  = !w_held_ff && !bvalid_ff;
  assign o_arready = !rvalid_ff;
  assign o_bvalid  = bvalid_ff;
  assign o_bresp   = bresp_ff;
  assign o_rvalid  = rvalid_ff;
  assign o_rdata   = rdata_ff;
  assign o_rresp   = rresp_ff;
  assign o_sleep   = (pwr_ff == PWR_SLEEP);
  assign o_osc_en  = (pwr_ff == PWR_RUN);

  // ************************************************************
  // Subtractor: minuend plus inverted subtrahend plus one
  // ************************************************************
  logic [7:0] sub_a;
  logic [7:0] sub_b;
  wire  [8:0] sub_full = {1'b0, sub_a} + {1'b0, ~sub_b} + 9'h001;
  wire  [4:0] sub_low  = {1'b0, sub_a[3:0]} + {1'b0, ~sub_b[3:0]} + 5'h01;

  // ************************************************************
  // Result and flag selection
  // ************************************************************
  logic [7:0] res;
  logic       to_acc;
  logic       to_file;
  logic       upd_c;
  logic       upd_dc;
  logic       upd_z;
  logic       new_c;

  always_comb begin
    sub_a   = fval;
    sub_b   = acc_ff;
    res     = 8'h00;
    to_acc  = 1'b0;
    to_file = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    new_c   = sub_full[8];
    unique case (cmd_op)
      OP_LIT_MINUS: begin
        sub_a  = cmd_lit;
        res    = sub_full[7:0];
        to_acc = 1'b1;
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_ROT_RIGHT: begin
        res   = {carry_ff, fval[7:1]};
        new_c = fval[0];
        upd_c = 1'b1;
      end
      OP_FILE_MINUS: begin
        res    = sub_full[7:0];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_NIBBLE_EX: begin
        res = {fval[3:0], fval[7:4]};
      end
      OP_XOR_LIT: begin
        res    = acc_ff ^ cmd_lit;
        to_acc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_XOR_FILE: begin
        res   = acc_ff ^ fval;
        upd_z = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
    if (cmd_op == OP_ROT_RIGHT || cmd_op == OP_FILE_MINUS ||
        cmd_op == OP_NIBBLE_EX || cmd_op == OP_XOR_FILE) begin
      to_acc  = !cmd_dest;
      to_file = cmd_dest;
    end
  end

  wire exec_acc  = cmd_exec && to_acc;
  wire exec_file = cmd_exec && to_file;
  wire exec_slp  = cmd_exec && (cmd_op == OP_SLEEP);
  wire presc_end = (wdog_presc_ff == BYTE_MAX);

  // ************************************************************
  // Bus channels
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_held_ff  <= 1'b0;
      wdata_ff   <= '0;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= i_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= i_wdata;
        wstrb_ff  <= i_wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read mux is decoded from the live address, captured on the AR handshake
  wire [DATA_W-1:0] stat_word = {26'h000_0000, o_sleep, timeout_flag_ff, powerdown_flag_ff,
                                 zero_ff, dc_ff, carry_ff};
  wire [DATA_W-1:0] rd_word =
    (rd_idx == IDX_ACC)   ? {24'h00_0000, acc_ff} :
    (rd_idx == IDX_STAT)  ? stat_word :
    (rd_idx == IDX_WDOG)  ? {16'h0000, wdog_presc_ff, watchdog_counter_ff} :
    (rd_idx == IDX_FADR)  ? {25'h000_0000, faddr_ff} :
    (rd_idx == IDX_FDATA) ? {24'h00_0000, file_ff[faddr_ff]} : 32'h0000_0000;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Accumulator, file registers, index
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= RST_BYTE;
    end else if (exec_acc) begin
      acc_ff <= res;
    end else if (wr_acc_sw) begin
      acc_ff <= wdata_ff[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_ff[i] <= RST_BYTE;
      end
    end else if (exec_file) begin
      file_ff[cmd_fadr] <= res;
    end else if (wr_fdat_sw) begin
      file_ff[faddr_ff] <= wdata_ff[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      faddr_ff <= '0;
    end else if (wr_fadr_sw) begin
      faddr_ff <= wdata_ff[FADR_W-1:0];
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carry_ff          <= 1'b0;
      dc_ff             <= 1'b0;
      zero_ff           <= 1'b0;
      timeout_flag_ff   <= RST_TO;
      powerdown_flag_ff <= RST_PD;
    end else if (cmd_exec) begin
      if (upd_c) begin
        carry_ff <= new_c;
      end
      if (upd_dc) begin
        dc_ff <= sub_low[4];
      end
      if (upd_z) begin
        zero_ff <= (res == 8'h00);
      end
      if (exec_slp) begin
        timeout_flag_ff   <= 1'b1;
        powerdown_flag_ff <= 1'b0;
      end
    end else if (wr_stat_sw) begin
      carry_ff          <= wdata_ff[ST_CARRY];
      dc_ff             <= wdata_ff[ST_DC];
      zero_ff           <= wdata_ff[ST_ZERO];
      powerdown_flag_ff <= wdata_ff[ST_PD];
      timeout_flag_ff   <= wdata_ff[ST_TO];
    end
  end

  // ************************************************************
  // Watchdog count and power state
  // ************************************************************
  // Prescaler wrap is the one-cycle enable of the slower watchdog rate
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdog_presc_ff       <= RST_BYTE;
      watchdog_counter_ff <= RST_BYTE;
    end else if (exec_slp) begin
      wdog_presc_ff       <= RST_BYTE;
      watchdog_counter_ff <= RST_BYTE;
    end else if (running) begin
      wdog_presc_ff <= wdog_presc_ff + 8'h01;
      if (presc_end) begin
        watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_ff <= PWR_RUN;
    end else if (exec_slp) begin
      pwr_ff <= PWR_SLEEP;
    end else if (wr_wake_sw) begin
      pwr_ff <= PWR_RUN;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_sleep_cmd;
    exec_slp;
  endsequence
  sequence s_asleep_held;
    o_sleep && !o_osc_en && !cmd_exec;
  endsequence

  a_sleep_flags: assert property (s_sleep_cmd |=> timeout_flag_ff && !powerdown_flag_ff)
    else $error("sleep did not set timeout and clear powerdown");
  a_sleep_wdog: assert property (s_sleep_cmd |=> watchdog_counter_ff == 8'h00
                                  && wdog_presc_ff == 8'h00)
    else $error("sleep did not clear watchdog count");
  a_sleep_halt: assert property (s_sleep_cmd ##1 !wr_wake_sw |=> s_asleep_held)
    else $error("core kept running after sleep");
  a_lit_minus: assert property (cmd_exec && cmd_op == OP_LIT_MINUS |=>
      acc_ff == $past(cmd_lit) - $past(acc_ff) && carry_ff == ($past(cmd_lit) >= $past(acc_ff)))
    else $error("literal minus accumulator wrong");
  a_rot_right: assert property (cmd_exec && cmd_op == OP_ROT_RIGHT && !cmd_dest |=>
      acc_ff == {$past(carry_ff), $past(fval[7:1])} && carry_ff == $past(fval[0])
      && zero_ff == $past(zero_ff) && dc_ff == $past(dc_ff))
    else $error("rotate right through carry wrong");
  a_dest_file: assert property (cmd_exec && to_file |=> acc_ff == $past(acc_ff)
      && file_ff[$past(cmd_fadr)] == $past(res))
    else $error("destination one did not write the file register");
  a_file_minus: assert property (cmd_exec && cmd_op == OP_FILE_MINUS |=>
      dc_ff == ($past(fval[3:0]) >= $past(acc_ff[3:0])) && zero_ff == ($past(fval) == $past(acc_ff)))
    else $error("file minus accumulator flags wrong");
  a_nibble_flags: assert property (cmd_exec && cmd_op == OP_NIBBLE_EX |=>
      $stable({carry_ff, dc_ff, zero_ff}) && (!$past(to_acc) || acc_ff == {$past(fval[3:0]),
      $past(fval[7:4])}))
    else $error("nibble exchange wrong");
  a_xor_lit: assert property (cmd_exec && cmd_op == OP_XOR_LIT |=>
      acc_ff == ($past(acc_ff) ^ $past(cmd_lit)) && carry_ff == $past(carry_ff))
    else $error("xor literal wrong");
  a_xor_zero: assert property (cmd_exec && cmd_op == OP_XOR_FILE |=>
      zero_ff == (($past(acc_ff) ^ $past(fval)) == 8'h00) && $stable(carry_ff))
    else $error("xor file zero flag wrong");

endmodule

// ---- bench/casl_core_tb.sv ----
// Self-checking bench of the ALU subset and sleep block.
// Assumes the block is reached only over its AXI4-Lite port; the bench is the bus master.
`timescale 1ns/1ps
module casl_core_tb;
  import casl_pkg::*;

  // ************************************************************
  // Signals and reference state
  // ************************************************************
  localparam int LIMIT = 100;
  logic              i_core_clk = 1'b0;
  logic              i_rst_n    = 1'b0;
  logic              i_awvalid  = 1'b0;
  logic [ADDR_W-1:0] i_awaddr   = 8'h00;
  logic              i_wvalid   = 1'b0;
  logic [DATA_W-1:0] i_wdata    = 32'h0000_0000;
  logic [3:0]        i_wstrb    = 4'hf;
  logic              i_bready   = 1'b0;
  logic              i_arvalid  = 1'b0;
  logic [ADDR_W-1:0] i_araddr   = 8'h00;
  logic              i_rready   = 1'b0;
  wire logic         o_awready;
  wire logic         o_wready;
  wire logic         o_bvalid;
  wire logic [1:0]   o_bresp;
  wire logic         o_arready;
  wire logic         o_rvalid;
  wire logic [DATA_W-1:0] o_rdata;
  wire logic [1:0]   o_rresp;
  wire logic         o_sleep;
  wire logic         o_osc_en;
  logic [33:0]       rq[$];
  logic [33:0]       bq[$];
  int                n_mismatch   = 0;
  int                total_checks = 0;
  integer            seed;
  logic [7:0]        m_acc;
  logic [7:0]        m_f;
  logic [7:0]        lit;
  logic [6:0]        fa;
  logic              dest;
  logic [4:0]        m_st;
  logic              m_sl;
  casl_op_e          op;

  casl_core dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_sleep(o_sleep), .o_osc_en(o_osc_en));

  always #4 i_core_clk = ~i_core_clk;

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Responses are paired with the oldest note, so order of issue is order of answer
  always @(posedge i_core_clk) begin
    if (o_rvalid === 1'b1 && i_rready) begin
      if (rq.size() > 0) chk("read", {o_rresp, o_rdata}, rq.pop_front());
      else chk("read_unexpected", 34'h0, 34'h1);
    end
    if (o_bvalid === 1'b1 && i_bready) begin
      if (bq.size() > 0) chk("bresp", 34'(o_bresp), bq.pop_front());
      else chk("bresp_unexpected", 34'h0, 34'h1);
    end
    // A pending answer must hold off any new request on its channel
    if (o_bvalid === 1'b1) chk("w_refused", 34'({o_awready, o_wready}), 34'h0);
    if (o_rvalid === 1'b1) chk("ar_refused", 34'(o_arready), 34'h0);
  end

  // ************************************************************
  // Bus master tasks
  // ************************************************************
  task automatic timeout_hit();
    n_mismatch++;
    complete_run();
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] strb,
                    input logic [1:0] eresp);
    int n;
    n = 0;
    bq.push_back(34'(eresp));
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_awaddr  <= {idx, 2'b00};
    i_wdata   <= d;
    i_wstrb   <= strb;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!(o_bvalid === 1'b1) && n < LIMIT);
    if (n >= LIMIT) timeout_hit();
    i_bready <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] eresp);
    int n;
    n = 0;
    rq.push_back({eresp, ed});
    i_arvalid <= 1'b1;
    i_araddr  <= {idx, 2'b00};
    i_rready  <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
      if (o_arready) i_arvalid <= 1'b0;
    end while (!(o_rvalid === 1'b1) && n < LIMIT);
    if (n >= LIMIT) timeout_hit();
    i_rready <= 1'b0;
    @(posedge i_core_clk);
  endtask

  // ************************************************************
  // Reference model
  // ************************************************************
  function automatic logic [31:0] stat_w();
    return {26'h0, m_sl, m_st};
  endfunction

  function automatic logic [31:0] cmd_w(input casl_op_e o);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CMD_OP_LSB +: 4] = o;
    w[CMD_DEST_BIT] = dest;
    w[CMD_FADR_LSB +: 7] = fa;
    w[CMD_LIT_LSB +: 8] = lit;
    return w;
  endfunction

  task automatic model(input casl_op_e o);
    logic [7:0] a;
    logic [7:0] r;
    a = (o == OP_LIT_MINUS) ? lit : m_f;
    r = m_acc;
    case (o)
      OP_LIT_MINUS, OP_FILE_MINUS: begin
        r = a - m_acc;
        m_st[ST_CARRY] = (a >= m_acc);
        m_st[ST_DC] = (a[3:0] >= m_acc[3:0]);
        m_st[ST_ZERO] = (r == 8'h00);
      end
      OP_ROT_RIGHT: begin
        r = {m_st[ST_CARRY], m_f[7:1]};
        m_st[ST_CARRY] = m_f[0];
      end
      OP_NIBBLE_EX: r = {m_f[3:0], m_f[7:4]};
      OP_XOR_LIT, OP_XOR_FILE: begin
        r = m_acc ^ ((o == OP_XOR_LIT) ? lit : m_f);
        m_st[ST_ZERO] = (r == 8'h00);
      end
      default: r = m_acc;
    endcase
    if (o == OP_LIT_MINUS || o == OP_XOR_LIT || !dest) m_acc = r;
    else m_f = r;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 32'hcab6_4fbf;
    m_sl = 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    rd(IDX_STAT, 32'h0000_0018, RESP_OKAY);
    rd(6'h07, 32'h0000_0000, RESP_SLVERR);
    wr(6'h3f, 32'($random(seed)), 4'hf, RESP_SLVERR);
    rd(IDX_CMD, 32'h0000_0000, RESP_OKAY);
    // Every ALU op, random destination bit, with operands forced equal every fifth pass (zero result for the minus and xor ops)
    for (int i = 0; i < 48; i++) begin
      op    = casl_op_e'(4'h2 + 4'(i % 6));
      m_acc = 8'($random(seed));
      m_f   = 8'($random(seed));
      lit   = 8'($random(seed));
      fa    = 7'($random(seed));
      dest  = 1'($random(seed));
      m_st  = 5'($random(seed));
      if (i % 5 == 0) begin
        lit = m_acc;
        m_f = m_acc;
      end
      wr(IDX_ACC, {24'h0, m_acc}, 4'hf, RESP_OKAY);
      wr(IDX_FADR, {25'h0, fa}, 4'hf, RESP_OKAY);
      wr(IDX_FDATA, {24'h0, m_f}, 4'hf, RESP_OKAY);
      wr(IDX_STAT, stat_w(), 4'hf, RESP_OKAY);
      wr(IDX_CMD, cmd_w(op), 4'hf, RESP_OKAY);
      model(op);
      rd(IDX_ACC, {24'h0, m_acc}, RESP_OKAY);
      rd(IDX_STAT, stat_w(), RESP_OKAY);
      rd(IDX_FDATA, {24'h0, m_f}, RESP_OKAY);
    end
    // Command lane disabled: no execution
    wr(IDX_CMD, cmd_w(OP_XOR_LIT), 4'he, RESP_OKAY);
    // No-operation code: nothing may change
    wr(IDX_CMD, cmd_w(OP_NOP), 4'hf, RESP_OKAY);
    rd(IDX_ACC, {24'h0, m_acc}, RESP_OKAY);
    rd(IDX_STAT, stat_w(), RESP_OKAY);
    rd(IDX_FDATA, {24'h0, m_f}, RESP_OKAY);
    // Let the watchdog count past a prescaler wrap before sleeping
    m_st = 5'b0_1101;
    wr(IDX_STAT, stat_w(), 4'hf, RESP_OKAY);
    repeat (300) @(posedge i_core_clk);
    wr(IDX_CMD, cmd_w(OP_SLEEP), 4'hf, RESP_OKAY);
    m_st[ST_TO] = 1'b1;
    m_st[ST_PD] = 1'b0;
    m_sl = 1'b1;
    chk("sleep", 34'(o_sleep), 34'h1);
    chk("osc_en", 34'(o_osc_en), 34'h0);
    rd(IDX_STAT, stat_w(), RESP_OKAY);
    rd(IDX_WDOG, 32'h0000_0000, RESP_OKAY);
    repeat (300) @(posedge i_core_clk);
    rd(IDX_WDOG, 32'h0000_0000, RESP_OKAY);
    wr(IDX_CMD, cmd_w(OP_XOR_LIT), 4'hf, RESP_OKAY);
    rd(IDX_ACC, {24'h0, m_acc}, RESP_OKAY);
    wr(IDX_WAKE, 32'($random(seed)), 4'hf, RESP_OKAY);
    m_sl = 1'b0;
    chk("sleep", 34'(o_sleep), 34'h0);
    chk("osc_en", 34'(o_osc_en), 34'h1);
    rd(IDX_WAKE, 32'h0000_0000, RESP_OKAY);
    // Reset in mid-run restores the flags
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    rd(IDX_STAT, 32'h0000_0018, RESP_OKAY);
    rd(IDX_ACC, 32'h0000_0000, RESP_OKAY);
    // Every noted answer must have been seen
    chk("queue", 34'(rq.size() + bq.size()), 34'h0);
    complete_run();
  end
endmodule
